// file: see_pkg.sv
package see_pkg;
	// ----------------------------------------
	// array and cache geometry
	// ----------------------------------------
	localparam int SEE_ADDR_W = 13;
	localparam int SEE_MEM_DEPTH = 8192;
	localparam int SEE_CACHE_DEPTH = 64;
	localparam int SEE_CIDX_W = 6;
	localparam int SEE_LINES = 8;
	localparam int SEE_LINE_BYTES = 8;
	localparam int SEE_OFS_W = 3;
	localparam int SEE_PAGES_W = 4;
	// ----------------------------------------
	// control and address byte fields
	// ----------------------------------------
	localparam int SEE_TYPE_MSB = 7;
	localparam int SEE_TYPE_LSB = 4;
	localparam int SEE_SEL_MSB = 3;
	localparam int SEE_SEL_LSB = 1;
	localparam int SEE_RW_BIT = 0;
	localparam int SEE_AHI_MSB = 4;
	// arbitrary value, not a real device type
	localparam logic [3:0] SEE_TYPE_CODE_DEFAULT = 4'h6;
	// ----------------------------------------
	// bit phase counts
	// ----------------------------------------
	localparam logic [3:0] SEE_BIT_FIRST = 4'h0;
	localparam logic [3:0] SEE_BIT_LAST = 4'h7;
	localparam logic [3:0] SEE_BIT_ACK = 4'h8;
	localparam logic [3:0] SEE_BIT_DONE = 4'h9;
	// ----------------------------------------
	// write cycle timing
	// ----------------------------------------
	localparam int SEE_WR_TIME_MS = 5;
	localparam int SEE_CLK_MHZ = 200;
	localparam int SEE_PAGE_WR_CYCLES = SEE_WR_TIME_MS * 1000 * SEE_CLK_MHZ;
	// ----------------------------------------
	// link states
	// ----------------------------------------
	typedef enum logic [2:0] {
		SEE_IDLE = 3'b000,
		SEE_CTRL = 3'b001,
		SEE_ADDRH = 3'b010,
		SEE_ADDRL = 3'b011,
		SEE_WDATA = 3'b100,
		SEE_RDATA = 3'b101
	} see_state_type;
endpackage

// file: see_top.sv
`timescale 1ns/1ps
// Behaviour
// R1: master starts only on idle bus
// R2: SDA fall with SCL high is START
// R3: SDA rise with SCL high is STOP
// R4: SDA changes only while SCL low
// R5: master sets byte count and clocks
// R6: addressed receiver acknowledges every byte
// R7: no acknowledge during programming cycle
// R8: acknowledge holds SDA low through clock high
// R9: master nacks last read byte; release SDA
// R10: control byte: type, select, direction
// R11: acknowledge only on type and strap match
// R12: two address bytes, high first, 13 bits
// R13: byte write acked each byte; STOP writes
// R14: cache up to 64 bytes, commit on STOP
// R15: data byte bumps low six pointer bits
// R16: offset wraps, cache line advances
// R17: full cache wraps to line zero
// R18: capture until STOP; STOP starts cycle
// R19: current read returns last address plus one
// R20: address load survives repeated START
// R21: master ack gives next sequential byte
// R22: first byte lands in line zero offset
// R23: busy time is pages times page time
// R24: sequential read wraps top to zero
module see_top #(
	parameter logic [3:0] TYPE_CODE = see_pkg::SEE_TYPE_CODE_DEFAULT,
	parameter int PAGE_WR_CYCLES = see_pkg::SEE_PAGE_WR_CYCLES
) (
	// system
	input wire logic clk_i,
	input wire logic sys_rst_i,
	// two-wire link
	input wire logic link_clk_i,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_o,
	// select straps
	input wire logic select_pin_high_i,
	input wire logic select_pin_middle_i,
	input wire logic select_pin_low_i,
	// status
	output logic write_busy_o
);
	localparam int AW = see_pkg::SEE_ADDR_W;
	localparam int CW = see_pkg::SEE_CIDX_W;
	localparam int PW = see_pkg::SEE_PAGES_W;
	localparam int OW = see_pkg::SEE_OFS_W;

	// ----------------------------------------
	// link reset and pin synchronisers
	// ----------------------------------------
	logic [1:0] lrst_q;
	logic link_rst;
	logic [4:0] pin_s1_q;
	logic [4:0] pin_s2_q;
	logic scl_p_q;
	logic sda_p_q;
	logic done_s1_q;
	logic done_s2_q;
	logic done_tgl_q;

	always_ff @(posedge link_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			lrst_q <= 2'h3;
		end else begin
			lrst_q <= {lrst_q[0], 1'b0};
		end
	end
	assign link_rst = lrst_q[1];

	always_ff @(posedge link_clk_i or posedge link_rst) begin
		if (link_rst) begin
			pin_s1_q <= 5'h1F;
			pin_s2_q <= 5'h1F;
			scl_p_q <= 1'b1;
			sda_p_q <= 1'b1;
			done_s1_q <= 1'b0;
			done_s2_q <= 1'b0;
		end else begin
			pin_s1_q <= {select_pin_high_i, select_pin_middle_i, select_pin_low_i, scl_i, sda_i};
			pin_s2_q <= pin_s1_q;
			scl_p_q <= pin_s2_q[1];
			sda_p_q <= pin_s2_q[0];
			done_s1_q <= done_tgl_q;
			done_s2_q <= done_s1_q;
		end
	end

	logic scl_s;
	logic sda_s;
	logic [2:0] sel_s;
	logic start_det;
	logic stop_det;
	logic scl_rise;
	logic scl_fall;
	assign scl_s = pin_s2_q[1];
	assign sda_s = pin_s2_q[0];
	assign sel_s = pin_s2_q[4:2];
	assign start_det = scl_s && scl_p_q && sda_p_q && !sda_s; // [R2]
	assign stop_det = scl_s && scl_p_q && !sda_p_q && sda_s; // [R3]
	assign scl_rise = scl_s && !scl_p_q;
	assign scl_fall = !scl_s && scl_p_q;

	// ----------------------------------------
	// storage: array and write cache
	// ----------------------------------------
	logic [7:0] mem [see_pkg::SEE_MEM_DEPTH];
	logic [7:0] cache [see_pkg::SEE_CACHE_DEPTH];
	logic c_we;
	logic a_we;
	logic [AW-1:0] a_addr;

	// ----------------------------------------
	// link engine state
	// ----------------------------------------
	see_pkg::see_state_type st_q, st_d;
	logic [3:0] bit_q, bit_d;
	logic [7:0] sh_q, sh_d;
	logic [7:0] tx_q, tx_d;
	logic [AW-1:0] ptr_q, ptr_d;
	logic [AW-1:0] base_q, base_d;
	logic [CW-1:0] idx_q, idx_d;
	logic [see_pkg::SEE_CACHE_DEPTH-1:0] vld_q, vld_d;
	logic ack_q, ack_d;
	logic rd_q, rd_d;
	logic mnack_q, mnack_d;
	logic oe_q, oe_d;
	logic busy_q, busy_d;
	logic req_tgl_q, req_tgl_d;
	logic [PW-1:0] pages_q, pages_d;
	logic cm_act_q, cm_act_d;
	logic [CW-1:0] cm_idx_q, cm_idx_d;
	logic done_seen_q, done_seen_d;
	logic [7:0] byte_in;
	logic [see_pkg::SEE_LINES-1:0] line_used;
	logic [PW-1:0] pages_cnt;

	assign byte_in = {sh_q[6:0], sda_s};

	// line occupancy for page count
	for (genvar l = 0; l < see_pkg::SEE_LINES; l++) begin : g_line
		assign line_used[l] = |vld_q[l*see_pkg::SEE_LINE_BYTES +: see_pkg::SEE_LINE_BYTES];
	end

	always_comb begin
		pages_cnt = '0;
		for (int l = 0; l < see_pkg::SEE_LINES; l++) begin
			pages_cnt = pages_cnt + PW'(line_used[l]);
		end
	end

	always_comb begin
		st_d = st_q;
		bit_d = bit_q;
		sh_d = sh_q;
		tx_d = tx_q;
		ptr_d = ptr_q;
		base_d = base_q;
		idx_d = idx_q;
		vld_d = vld_q;
		ack_d = ack_q;
		rd_d = rd_q;
		mnack_d = mnack_q;
		oe_d = oe_q;
		busy_d = busy_q;
		req_tgl_d = req_tgl_q;
		pages_d = pages_q;
		cm_act_d = cm_act_q;
		cm_idx_d = cm_idx_q;
		done_seen_d = done_seen_q;
		c_we = 1'b0;
		a_we = 1'b0;
		a_addr = {base_q[AW-1:CW], base_q[CW-1:0] + cm_idx_q};
		// cache commit into array
		if (cm_act_q) begin
			a_we = vld_q[cm_idx_q]; // [R14]
			cm_idx_d = cm_idx_q + CW'(1);
			if (&cm_idx_q) begin
				cm_act_d = 1'b0;
			end
		end
		// write cycle finished in system domain
		if (done_s2_q != done_seen_q) begin
			done_seen_d = done_s2_q;
			busy_d = 1'b0;
		end
		if (start_det) begin // [R2] [R20]
			st_d = see_pkg::SEE_CTRL;
			bit_d = see_pkg::SEE_BIT_FIRST;
			oe_d = 1'b0;
		end else if (stop_det) begin // [R3]
			if (st_q == see_pkg::SEE_WDATA && (|vld_q)) begin // [R13] [R18]
				busy_d = 1'b1;
				req_tgl_d = !req_tgl_q;
				pages_d = pages_cnt; // [R23]
				cm_act_d = 1'b1;
				cm_idx_d = '0;
			end
			st_d = see_pkg::SEE_IDLE;
			bit_d = see_pkg::SEE_BIT_FIRST;
			oe_d = 1'b0;
		end else if (st_q != see_pkg::SEE_IDLE && scl_rise) begin // [R4]
			if (bit_q < see_pkg::SEE_BIT_ACK) begin
				sh_d = byte_in;
				bit_d = bit_q + 4'h1;
			end else if (bit_q == see_pkg::SEE_BIT_ACK) begin
				bit_d = see_pkg::SEE_BIT_DONE;
				mnack_d = sda_s; // [R9] [R21]
			end
			if (bit_q == see_pkg::SEE_BIT_LAST) begin
				ack_d = 1'b0;
				unique case (st_q)
					see_pkg::SEE_CTRL: begin
						if (byte_in[see_pkg::SEE_TYPE_MSB:see_pkg::SEE_TYPE_LSB] == TYPE_CODE
							&& byte_in[see_pkg::SEE_SEL_MSB:see_pkg::SEE_SEL_LSB] == sel_s
							&& !busy_q) begin // [R10] [R11] [R7]
							ack_d = 1'b1;
							rd_d = byte_in[see_pkg::SEE_RW_BIT];
							if (!byte_in[see_pkg::SEE_RW_BIT]) begin
								vld_d = '0;
							end
						end
					end
					see_pkg::SEE_ADDRH: begin
						ack_d = 1'b1;
						ptr_d[AW-1:8] = byte_in[see_pkg::SEE_AHI_MSB:0]; // [R12]
					end
					see_pkg::SEE_ADDRL: begin
						ack_d = 1'b1;
						ptr_d[7:0] = byte_in; // [R20]
						base_d = {ptr_q[AW-1:8], byte_in[7:OW], OW'(0)};
						idx_d = {3'h0, byte_in[OW-1:0]}; // [R22]
					end
					see_pkg::SEE_WDATA: begin
						ack_d = 1'b1; // [R6] [R13]
						c_we = 1'b1; // [R14] [R18]
						vld_d[idx_q] = 1'b1;
						idx_d = idx_q + CW'(1); // [R16] [R17]
						ptr_d[CW-1:0] = ptr_q[CW-1:0] + CW'(1); // [R15]
					end
					see_pkg::SEE_RDATA: begin
						ack_d = 1'b0;
					end
					default: begin
						ack_d = 1'b0;
					end
				endcase
			end
		end else if (st_q != see_pkg::SEE_IDLE && scl_fall) begin // [R4]
			if (bit_q == see_pkg::SEE_BIT_ACK) begin
				oe_d = ack_q && st_q != see_pkg::SEE_RDATA; // [R6] [R8]
			end else if (bit_q == see_pkg::SEE_BIT_DONE) begin
				bit_d = see_pkg::SEE_BIT_FIRST;
				oe_d = 1'b0;
				unique case (st_q)
					see_pkg::SEE_CTRL: begin
						if (!ack_q) begin
							st_d = see_pkg::SEE_IDLE; // [R7]
						end else if (rd_q) begin
							st_d = see_pkg::SEE_RDATA; // [R19]
							tx_d = mem[ptr_q];
							ptr_d = ptr_q + AW'(1);
							oe_d = !mem[ptr_q][7];
						end else begin
							st_d = see_pkg::SEE_ADDRH;
						end
					end
					see_pkg::SEE_ADDRH: begin
						st_d = see_pkg::SEE_ADDRL;
					end
					see_pkg::SEE_ADDRL: begin
						st_d = see_pkg::SEE_WDATA;
					end
					see_pkg::SEE_WDATA: begin
						st_d = see_pkg::SEE_WDATA;
					end
					see_pkg::SEE_RDATA: begin
						if (mnack_q) begin
							st_d = see_pkg::SEE_IDLE; // [R9]
						end else begin
							tx_d = mem[ptr_q]; // [R21]
							ptr_d = ptr_q + AW'(1); // [R24]
							oe_d = !mem[ptr_q][7];
						end
					end
					default: begin
						st_d = see_pkg::SEE_IDLE;
					end
				endcase
			end else if (st_q == see_pkg::SEE_RDATA) begin
				oe_d = !tx_q[3'h7 - bit_q[2:0]]; // [R4]
			end
		end
	end

	always_ff @(posedge link_clk_i or posedge link_rst) begin
		if (link_rst) begin
			st_q <= see_pkg::SEE_IDLE;
			bit_q <= see_pkg::SEE_BIT_FIRST;
			sh_q <= 8'h00;
			tx_q <= 8'h00;
			ptr_q <= '0;
			base_q <= '0;
			idx_q <= '0;
			vld_q <= '0;
			ack_q <= 1'b0;
			rd_q <= 1'b0;
			mnack_q <= 1'b1;
			oe_q <= 1'b0;
			busy_q <= 1'b0;
			req_tgl_q <= 1'b0;
			pages_q <= '0;
			cm_act_q <= 1'b0;
			cm_idx_q <= '0;
			done_seen_q <= 1'b0;
		end else begin
			st_q <= st_d;
			bit_q <= bit_d;
			sh_q <= sh_d;
			tx_q <= tx_d;
			ptr_q <= ptr_d;
			base_q <= base_d;
			idx_q <= idx_d;
			vld_q <= vld_d;
			ack_q <= ack_d;
			rd_q <= rd_d;
			mnack_q <= mnack_d;
			oe_q <= oe_d;
			busy_q <= busy_d;
			req_tgl_q <= req_tgl_d;
			pages_q <= pages_d;
			cm_act_q <= cm_act_d;
			cm_idx_q <= cm_idx_d;
			done_seen_q <= done_seen_d;
		end
	end

	always_ff @(posedge link_clk_i) begin
		if (c_we) begin
			cache[idx_q] <= byte_in;
		end
		if (a_we) begin
			mem[a_addr] <= cache[cm_idx_q];
		end
	end

	// ----------------------------------------
	// write cycle timer, system domain
	// ----------------------------------------
	logic req_s1_q;
	logic req_s2_q;
	logic req_s3_q;
	logic run_q, run_d;
	logic [PW-1:0] left_q, left_d;
	logic [31:0] cyc_q, cyc_d;
	logic done_tgl_d;

	always_comb begin
		run_d = run_q;
		left_d = left_q;
		cyc_d = cyc_q;
		done_tgl_d = done_tgl_q;
		if (req_s2_q != req_s3_q) begin
			run_d = 1'b1;
			left_d = pages_q; // [R23]
			cyc_d = 32'(PAGE_WR_CYCLES - 1);
		end else if (run_q) begin
			if (cyc_q != 32'h0) begin
				cyc_d = cyc_q - 32'h1;
			end else if (left_q <= PW'(1)) begin
				run_d = 1'b0;
				done_tgl_d = !done_tgl_q;
			end else begin
				left_d = left_q - PW'(1);
				cyc_d = 32'(PAGE_WR_CYCLES - 1);
			end
		end
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			req_s1_q <= 1'b0;
			req_s2_q <= 1'b0;
			req_s3_q <= 1'b0;
			run_q <= 1'b0;
			left_q <= '0;
			cyc_q <= 32'h0;
			done_tgl_q <= 1'b0;
			write_busy_o <= 1'b0;
		end else begin
			req_s1_q <= req_tgl_q;
			req_s2_q <= req_s1_q;
			req_s3_q <= req_s2_q;
			run_q <= run_d;
			left_q <= left_d;
			cyc_q <= cyc_d;
			done_tgl_q <= done_tgl_d;
			write_busy_o <= run_d;
		end
	end

	// ----------------------------------------
	// pin drivers
	// ----------------------------------------
	always_ff @(posedge link_clk_i or posedge link_rst) begin
		if (link_rst) begin
			sda_o <= 1'b0;
			sda_oe_o <= 1'b0;
		end else begin
			sda_o <= 1'b0;
			sda_oe_o <= oe_d; // [R8]
		end
	end
endmodule

// file: see_top_assertions.sv
`timescale 1ns/1ps
module see_top_assertions #(
	parameter int PAGE_WR_CYCLES = 20
) (
	// clocks and reset
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic link_clk_i,
	// link and status
	input wire logic scl_i,
	input wire logic sda_i,
	input wire logic sda_o,
	input wire logic sda_oe_o,
	input wire logic write_busy_o
);
	logic [31:0] busy_cnt_q;
	logic [31:0] busy_cnt_d;
	sequence start_seq;
		scl_i && $fell(sda_i);
	endsequence
	sequence stop_seq;
		scl_i && $rose(sda_i);
	endsequence
	always_comb begin
		busy_cnt_d = write_busy_o ? busy_cnt_q + 32'h00000001 : 32'h00000000;
	end
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			busy_cnt_q <= 32'h00000000;
		end else begin
			busy_cnt_q <= busy_cnt_d;
		end
	end
	a_drive_low_only: assert property (@(posedge link_clk_i) disable iff (sys_rst_i)
		sda_o == 1'b0) else $error("sda_o high");
	a_change_scl_low: assert property (@(posedge link_clk_i) disable iff (sys_rst_i)
		$changed(sda_oe_o) |-> !scl_i && !$past(scl_i, 3)) else $error("drive moved late");
	a_hold_high: assert property (@(posedge link_clk_i) disable iff (sys_rst_i)
		sda_oe_o && $rose(scl_i) |-> sda_oe_o [*4]) else $error("drive lost");
	a_busy_no_ack: assert property (@(posedge link_clk_i) disable iff (sys_rst_i)
		write_busy_o |-> !sda_oe_o) else $error("drive while busy");
	a_start_quiet: assert property (@(posedge link_clk_i) disable iff (sys_rst_i)
		start_seq |-> !sda_oe_o [*4]) else $error("drive after start");
	a_stop_quiet: assert property (@(posedge link_clk_i) disable iff (sys_rst_i)
		stop_seq |-> !sda_oe_o [*4]) else $error("drive after stop");
	a_busy_pages: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		$fell(write_busy_o) |-> busy_cnt_q >= PAGE_WR_CYCLES
		&& busy_cnt_q % PAGE_WR_CYCLES < 8) else $error("busy not whole pages");
	a_busy_bound: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		write_busy_o |-> busy_cnt_q < 8 * PAGE_WR_CYCLES + 8) else $error("busy too long");
endmodule
bind see_top see_top_assertions #(.PAGE_WR_CYCLES(PAGE_WR_CYCLES)) i_see_top_assertions (
	.clk_i(clk_i), .sys_rst_i(sys_rst_i), .link_clk_i(link_clk_i), .scl_i(scl_i),
	.sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .write_busy_o(write_busy_o));

// file: see_master.sv
`timescale 1ns/1ps
module see_master #(
	parameter int Q = 3
) (
	// link side
	input wire logic link_clk_i,
	input wire logic sda_i,
	output logic scl_o,
	output logic sda_low_o
);
	initial begin
		scl_o = 1'b1;
		sda_low_o = 1'b0;
	end
	task automatic wt(input int n);
		repeat (n) @(posedge link_clk_i);
		#1;
	endtask
	task automatic bit_x(input logic b, output logic s);
		wt(Q);
		sda_low_o = !b;
		wt(Q);
		scl_o = 1'b1;
		wt(Q);
		s = sda_i;
		wt(Q);
		scl_o = 1'b0;
	endtask
	task automatic start();
		wt(Q);
		sda_low_o = 1'b0;
		wt(Q);
		scl_o = 1'b1;
		wt(2 * Q);
		sda_low_o = 1'b1;
		wt(2 * Q);
		scl_o = 1'b0;
	endtask
	task automatic stop();
		wt(Q);
		sda_low_o = 1'b1;
		wt(Q);
		scl_o = 1'b1;
		wt(2 * Q);
		sda_low_o = 1'b0;
		wt(4 * Q);
	endtask
	// eight bits msb first, then the ninth clock
	task automatic xfer(input logic [7:0] tx, input logic nb, output logic [7:0] rx,
		output logic ns);
		for (int i = 7; i >= 0; i--) begin
			bit_x(tx[i], rx[i]);
		end
		bit_x(nb, ns);
	endtask
endmodule

// file: test_serial_eeprom_two_wire_slave.sv
`timescale 1ns/1ps
module test_serial_eeprom_two_wire_slave;
	// arbitrary value, not a real device type
	localparam logic [3:0] TC = 4'h9;
	localparam int P = 2000;
	logic clk_i = 1'b0;
	logic link_clk = 1'b0;
	logic rst = 1'b1;
	logic scl;
	logic sda_low;
	logic sda_o;
	logic sda_oe;
	logic busy;
	logic [2:0] sel;
	logic [15:0] busy_cnt = 16'h0000;
	logic [7:0] mem_m [0:8191];
	int seed = 32'h637581B8;
	int failures = 0;
	int checks_done = 0;
	wire logic sda = !(sda_low || (sda_oe && !sda_o));
	see_top #(.TYPE_CODE(TC), .PAGE_WR_CYCLES(P)) i_see_top (.clk_i(clk_i), .sys_rst_i(rst),
		.link_clk_i(link_clk), .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe),
		.select_pin_high_i(sel[2]), .select_pin_middle_i(sel[1]), .select_pin_low_i(sel[0]),
		.write_busy_o(busy));
	see_master i_see_master (.link_clk_i(link_clk), .sda_i(sda), .scl_o(scl),
		.sda_low_o(sda_low));
	always #2.5 clk_i = !clk_i;
	initial begin
		#7;
		forever #32 link_clk = !link_clk;
	end
	always @(posedge clk_i) begin
		if (busy === 1'b1) begin
			busy_cnt = busy_cnt + 16'h0001;
		end
	end
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		checks_done++;
		if (g !== e) begin
			failures++;
			$display("ERROR %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic summarize();
		if (failures == 0 && checks_done > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic ctrl(input logic [3:0] t, input logic [2:0] s, input logic rw, input logic ack);
		logic [7:0] rx;
		logic k;
		i_see_master.start();
		i_see_master.xfer({t, s, rw}, 1'b1, rx, k);
		chk("ctrl ack", {15'h0, ack}, {15'h0, !k});
	endtask
	task automatic load(input logic [12:0] a, input int n);
		logic [15:0] w;
		logic [7:0] d;
		logic [7:0] rx;
		logic k;
		w = {3'h0, a};
		ctrl(TC, sel, 1'b0, 1'b1);
		for (int i = 0; i < n + 2; i++) begin
			d = (i < 2) ? w[15 - 8 * i -: 8] : 8'($random(seed));
			if (i > 1) begin
				mem_m[{a[12:6], 6'(a[5:0] + i - 2)}] = d;
			end
			i_see_master.xfer(d, 1'b1, rx, k);
			chk("write ack", 16'h0000, {15'h0, k});
		end
	endtask
	task automatic wr(input logic [12:0] a, input int n, input logic poll);
		load(a, n);
		busy_cnt = 16'h0000;
		i_see_master.stop();
		if (poll) begin
			ctrl(TC, sel, 1'b0, 1'b0);
			i_see_master.stop();
		end
		for (int t = 0; t < 40000 && (busy_cnt == 0 || busy !== 1'b0); t++) begin
			@(posedge clk_i);
		end
		repeat (8) @(posedge link_clk);
		chk("pages", 16'((a[2:0] + n - 1) / 8 + 1), busy_cnt / P);
	endtask
	task automatic rd(input logic [12:0] a, input int n, input logic cur);
		logic [7:0] rx;
		logic k;
		if (!cur) begin
			load(a, 0);
		end
		ctrl(TC, sel, 1'b1, 1'b1);
		for (int i = 0; i < n; i++) begin
			i_see_master.xfer(8'hFF, i == n - 1, rx, k);
			chk("read data", {8'h00, mem_m[13'(a + i)]}, {8'h00, rx});
		end
		i_see_master.stop();
	endtask
	initial begin
		sel = 3'($random(seed));
		repeat (10) @(posedge link_clk);
		#1;
		rst = 1'b0;
		repeat (6) @(posedge link_clk);
		for (int s = 0; s < 8; s++) begin
			ctrl(TC, 3'(s), 1'b0, 3'(s) == sel);
			i_see_master.stop();
		end
		ctrl(~TC, sel, 1'b0, 1'b0);
		i_see_master.stop();
		wr(13'($random(seed)), 1, 1'b1);
		wr(13'h1FFE, 10, 1'b0);
		wr(13'h0000, 2, 1'b0);
		busy_cnt = 16'h0000;
		rd(13'h1FC6, 2, 1'b0);
		rd(13'h1FFE, 3, 1'b0);
		rd(13'h0001, 1, 1'b1);
		chk("abort busy", 16'h0000, busy_cnt);
		summarize();
	end
	initial begin
		#480000;
		failures++;
		summarize();
	end
endmodule
